// ===== verification/i2c_host_model.sv
// Purpose: serial bus host for the divider port
// Assumes: sda pulled up, host bit 1 releases the line
// Notes: one bit takes eight core cycles, 800 ns
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic w2();
    repeat (2) @(posedge core_clk);
  endtask
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    w2();
    sda_drv <= b;
    w2();
    scl <= 1'b1;
    w2();
    s = sda_line;
    w2();
  endtask
  task automatic start_c();
    sda_drv <= 1'b0;
    w2();
  endtask
  task automatic stop_c();
    scl <= 1'b0;
    w2();
    sda_drv <= 1'b0;
    w2();
    scl <= 1'b1;
    w2();
    sda_drv <= 1'b1;
    w2();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ===== verification/synth_divider_config_port_test.sv
// Purpose: self-checking bench for the divider configuration port
// Assumes: open-drain sda with pull-up
// Notes: model keeps latches as {fb, post a, post b, pre}
`timescale 1ns/1ns
`default_nettype none
module synth_divider_config_port_test;
  logic        core_clk;
  logic        reset_n;
  logic        parallel_select_n;
  logic [1:0]  addr_sel;
  logic [9:0]  fb_pins;
  logic [2:0]  post_a_pins;
  logic        post_b_pin;
  logic        pre_pin;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  logic [9:0]  fb_div;
  logic [2:0]  post_divider_a;
  logic        post_divider_b;
  logic        pre_div;
  logic [14:0] m_div;
  logic [14:0] m_def;
  logic [7:0]  m_lo;
  logic [7:0]  m_hi;
  logic        m_ser;
  logic [31:0] seed;
  logic [7:0]  wq[$];
  logic [7:0]  cmds[5];
  int          n_errors;
  int          num_checks;
  wire  logic  sda_line;
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  synth_divider_config_port synth_divider_config_port_i (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .parallel_select_n (parallel_select_n),
    .addr_sel          (addr_sel),
    .fb_pins           (fb_pins),
    .post_a_pins       (post_a_pins),
    .post_b_pin        (post_b_pin),
    .pre_pin           (pre_pin),
    .scl               (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .fb_div            (fb_div),
    .post_divider_a    (post_divider_a),
    .post_divider_b    (post_divider_b),
    .pre_div           (pre_div)
  );
  i2c_host_model i2c_host_model_i (
    .core_clk (core_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );
  function automatic void roll();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  task automatic mirror();
    m_lo = m_div[12:5];
    m_hi = {1'b0, m_div[0], m_div[1], m_div[4:2], m_div[14:13]};
  endtask
  task automatic apply(input logic [7:0] r, input logic [7:0] d);
    if (r == synth_cfg_pkg::ADDR_CFG_LOW) m_lo = d;
    if (r == synth_cfg_pkg::ADDR_CFG_HIGH) m_hi = d & synth_cfg_pkg::HI_USED_MASK;
    if (r != synth_cfg_pkg::ADDR_COMMAND) return;
    if (d == synth_cfg_pkg::CMD_COMMIT) m_div = {m_hi[1:0], m_lo, m_hi[4:2], m_hi[5], m_hi[6]};
    if (d == synth_cfg_pkg::CMD_CAPTURE) mirror();
    if (d == synth_cfg_pkg::CMD_STEP_UP) m_div[14:5] += 10'h1;
    if (d == synth_cfg_pkg::CMD_STEP_DOWN) m_div[14:5] -= 10'h1;
  endtask
  task automatic check_div();
    num_checks++;
    if ({fb_div, post_divider_a, post_divider_b, pre_div} !== m_div) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
               {fb_div, post_divider_a, post_divider_b, pre_div}, m_div);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_xfer(input logic [1:0] sel);
    logic ack;
    i2c_host_model_i.start_c();
    i2c_host_model_i.put_byte({synth_cfg_pkg::SLAVE_ADDR_HI, sel, 1'b0}, ack);
    check_byte({7'h0, ack}, {7'h0, sel == addr_sel});
    if (sel != addr_sel) wq = {};
    for (int i = 0; i < wq.size(); i++) begin
      i2c_host_model_i.put_byte(wq[i], ack);
      check_byte({7'h0, ack}, 8'h01);
      if (i % 2 == 1 && m_ser) apply(wq[i-1], wq[i]);
    end
    i2c_host_model_i.stop_c();
    wq = {};
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd_xfer();
    logic       ack;
    logic [7:0] d;
    i2c_host_model_i.start_c();
    i2c_host_model_i.put_byte({synth_cfg_pkg::SLAVE_ADDR_HI, addr_sel, 1'b1}, ack);
    check_byte({7'h0, ack}, 8'h01);
    i2c_host_model_i.get_byte(1'b0, d);
    check_byte(d, m_lo);
    i2c_host_model_i.get_byte(1'b0, d);
    check_byte(d, m_hi);
    i2c_host_model_i.get_byte(1'b1, d);
    check_byte(d, synth_cfg_pkg::SIGNATURE);
    i2c_host_model_i.stop_c();
    repeat (2) @(posedge core_clk);
  endtask
  task automatic set_pins();
    roll();
    {fb_pins, post_a_pins, post_b_pin, pre_pin} <= seed[14:0];
    if (!m_ser) m_div = seed[14:0];
    repeat (4) @(posedge core_clk);
    if (!m_ser) mirror();
  endtask
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #5000000;
    n_errors++;
    close_out();
  end
  initial begin
    seed = 32'h53;
    n_errors = 0;
    num_checks = 0;
    m_ser = 1'b0;
    reset_n = 1'b0;
    parallel_select_n = 1'b0;
    addr_sel = 2'h2;
    m_def = {synth_cfg_pkg::DEF_FB, synth_cfg_pkg::DEF_POST_A, synth_cfg_pkg::DEF_POST_B, synth_cfg_pkg::DEF_PRE};
    m_div = m_def;
    {fb_pins, post_a_pins, post_b_pin, pre_pin} = m_def;
    mirror();
    cmds = '{synth_cfg_pkg::CMD_COMMIT, synth_cfg_pkg::CMD_STEP_UP, synth_cfg_pkg::CMD_CAPTURE,
             synth_cfg_pkg::CMD_STEP_DOWN, 8'h07};
    repeat (20) @(posedge core_clk);
    check_div();
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check_div();
    rd_xfer();
    repeat (3) begin
      set_pins();
      check_div();
      rd_xfer();
    end
    roll();
    wq = {synth_cfg_pkg::ADDR_CFG_LOW, seed[7:0], synth_cfg_pkg::ADDR_COMMAND, synth_cfg_pkg::CMD_COMMIT};
    wr_xfer(addr_sel);
    check_div();
    rd_xfer();
    parallel_select_n <= 1'b1;
    m_ser = 1'b1;
    addr_sel <= 2'h1;
    repeat (4) @(posedge core_clk);
    set_pins();
    check_div();
    rd_xfer();
    roll();
    wq = {synth_cfg_pkg::ADDR_CFG_HIGH, seed[7:0], synth_cfg_pkg::ADDR_CFG_LOW, seed[15:8]};
    wr_xfer(addr_sel);
    check_div();
    rd_xfer();
    foreach (cmds[i]) begin
      wq = {synth_cfg_pkg::ADDR_COMMAND, cmds[i]};
      wr_xfer(addr_sel);
      check_div();
      rd_xfer();
    end
    wq = {synth_cfg_pkg::ADDR_CFG_LOW, 8'hff, synth_cfg_pkg::ADDR_CFG_HIGH, 8'h03,
          synth_cfg_pkg::ADDR_COMMAND, synth_cfg_pkg::CMD_COMMIT, synth_cfg_pkg::ADDR_COMMAND, synth_cfg_pkg::CMD_STEP_UP};
    wr_xfer(addr_sel);
    check_div();
    wq = {synth_cfg_pkg::ADDR_COMMAND, synth_cfg_pkg::CMD_STEP_DOWN};
    wr_xfer(addr_sel ^ 2'h1);
    check_div();
    parallel_select_n <= 1'b0;
    m_ser = 1'b0;
    m_div = {fb_pins, post_a_pins, post_b_pin, pre_pin};
    mirror();
    repeat (4) @(posedge core_clk);
    check_div();
    rd_xfer();
    parallel_select_n <= 1'b1;
    m_ser = 1'b1;
    repeat (4) @(posedge core_clk);
    set_pins();
    reset_n <= 1'b0;
    m_div = m_def;
    repeat (2) @(posedge core_clk);
    check_div();
    reset_n <= 1'b1;
    m_div = {fb_pins, post_a_pins, post_b_pin, pre_pin};
    mirror();
    repeat (6) @(posedge core_clk);
    check_div();
    rd_xfer();
    close_out();
  end
endmodule // synth_divider_config_port_test
`default_nettype wire

// ===== verilog/cfg_bus_if.sv
// Purpose: register access path between the serial port and the register file
// Assumes: all signals on core_clk
// Notes: wr_stb is a one-cycle pulse, rd_data is combinational
`timescale 1ns/1ns
`default_nettype none
interface cfg_bus_if;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [1:0] rd_idx;
  logic [7:0] rd_data;
  modport port_side (output wr_stb, output wr_addr, output wr_data, output rd_idx, input rd_data);
  modport reg_side  (input wr_stb, input wr_addr, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ===== verilog/i2c_slave_port.sv
// Purpose: serial slave, turns bus bytes into register writes and read stream
// Assumes: scl and sda sampled by core_clk, far slower than it
// Notes: open-drain sda, oe high pulls the line low
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_port (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic [1:0] addr_sel,
  output logic            sda_out,
  output logic            sda_oe,
  cfg_bus_if.port_side    bus
);
  logic [1:0] line_s;
  logic       scl_q, sda_q;
  synth_cfg_pkg::i2c_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, raddr_q, raddr_d, wdata_q, wdata_d;
  logic       first_q, first_d, read_q, read_d, phase_q, phase_d;
  logic       drive_q, drive_d, nack_q, nack_d, wstb_q, wstb_d;
  logic [1:0] idx_q, idx_d;

  pin_sync #(.WIDTH(2)) u_line_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    // lines kept inverted so the cleared stages match the idle-high bus
    .pin_in   ({~scl, ~sda_in}),
    .pin_out  (line_s)
  );

  wire scl_s    = ~line_s[1];
  wire sda_s    = ~line_s[0];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire addr_hit = (shift_q[7:3] == synth_cfg_pkg::SLAVE_ADDR_HI) && (shift_q[2:1] == addr_sel);

  assign sda_out     = 1'b0;
  assign sda_oe      = drive_q;
  assign bus.wr_stb  = wstb_q;
  assign bus.wr_addr = raddr_q;
  assign bus.wr_data = wdata_q;
  assign bus.rd_idx  = idx_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    raddr_d = raddr_q;
    wdata_d = wdata_q;
    first_d = first_q;
    read_d  = read_q;
    phase_d = phase_q;
    drive_d = drive_q;
    nack_d  = nack_q;
    idx_d   = idx_q;
    wstb_d  = 1'b0;
    if (start_c) begin
      state_d = synth_cfg_pkg::st_rx;
      cnt_d   = 4'h0;
      first_d = 1'b1;
      phase_d = 1'b0;
      drive_d = 1'b0;
    end else if (stop_c) begin
      state_d = synth_cfg_pkg::st_idle;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        synth_cfg_pkg::st_rx: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == synth_cfg_pkg::BITS_PER_BYTE) begin
            if (first_q) begin
              if (addr_hit) begin
                state_d = synth_cfg_pkg::st_ack;
                drive_d = 1'b1;
                read_d  = shift_q[0];
                idx_d   = synth_cfg_pkg::RD_IDX_LOW;
              end else begin
                state_d = synth_cfg_pkg::st_idle;
              end
            end else begin
              state_d = synth_cfg_pkg::st_ack;
              drive_d = 1'b1;
              phase_d = ~phase_q;
              if (!phase_q) begin
                raddr_d = shift_q;
              end else begin
                wdata_d = shift_q;
                wstb_d  = 1'b1;
              end
            end
          end
        end
        synth_cfg_pkg::st_ack: begin
          if (scl_fall) begin
            first_d = 1'b0;
            cnt_d   = 4'h0;
            if (read_q) begin
              state_d = synth_cfg_pkg::st_tx;
              shift_d = bus.rd_data;
              drive_d = ~bus.rd_data[7];
              idx_d   = synth_cfg_pkg::next_idx(idx_q);
            end else begin
              state_d = synth_cfg_pkg::st_rx;
              drive_d = 1'b0;
            end
          end
        end
        synth_cfg_pkg::st_tx: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == synth_cfg_pkg::LAST_TX_BIT) begin
              state_d = synth_cfg_pkg::st_rack;
              drive_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
            end
          end
        end
        synth_cfg_pkg::st_rack: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_d = synth_cfg_pkg::st_idle;
            end else begin
              state_d = synth_cfg_pkg::st_tx;
              cnt_d   = 4'h0;
              shift_d = bus.rd_data;
              drive_d = ~bus.rd_data[7];
              idx_d   = synth_cfg_pkg::next_idx(idx_q);
            end
          end
        end
        default: state_d = synth_cfg_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      state_q <= synth_cfg_pkg::st_idle;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      raddr_q <= 8'h00;
      wdata_q <= 8'h00;
      first_q <= 1'b0;
      read_q  <= 1'b0;
      phase_q <= 1'b0;
      drive_q <= 1'b0;
      nack_q  <= 1'b0;
      idx_q   <= synth_cfg_pkg::RD_IDX_LOW;
      wstb_q  <= 1'b0;
    end else begin
      scl_q   <= scl_s;
      sda_q   <= sda_s;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      raddr_q <= raddr_d;
      wdata_q <= wdata_d;
      first_q <= first_d;
      read_q  <= read_d;
      phase_q <= phase_d;
      drive_q <= drive_d;
      nack_q  <= nack_d;
      idx_q   <= idx_d;
      wstb_q  <= wstb_d;
    end
  end

  property p_ack_drive;
    @(posedge core_clk) disable iff (!reset_n)
    (state_q == synth_cfg_pkg::st_ack) |-> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack slot not driven low");

  property p_read_first;
    @(posedge core_clk) disable iff (!reset_n)
    (state_q == synth_cfg_pkg::st_ack && read_q && scl_fall && !start_c && !stop_c)
      |=> (shift_q == $past(bus.rd_data)) && (idx_q == synth_cfg_pkg::RD_IDX_HIGH);
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("read stream did not start with low config byte");
endmodule // i2c_slave_port
`default_nettype wire

// ===== verilog/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: pins are quasi-static against core_clk
// Notes: only the second stage is visible
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ===== verilog/synth_cfg_pkg.sv
// Purpose: shared constants and types of the divider configuration port
// Assumes: 8-bit register bytes, 7-bit serial slave address
// Notes: high config byte packs fb[9:8], post A, post B, pre, bit 7 reserved
package synth_cfg_pkg;
  // register addresses carried by the write protocol
  localparam logic [7:0] ADDR_CFG_LOW   = 8'h00;
  localparam logic [7:0] ADDR_CFG_HIGH  = 8'h01;
  localparam logic [7:0] ADDR_COMMAND   = 8'hf0;
  // command byte values
  localparam logic [7:0] CMD_COMMIT     = 8'h01;
  localparam logic [7:0] CMD_CAPTURE    = 8'h02;
  localparam logic [7:0] CMD_STEP_UP    = 8'h03;
  localparam logic [7:0] CMD_STEP_DOWN  = 8'h04;
  // upper five bits of the slave address
  localparam logic [4:0] SLAVE_ADDR_HI  = 5'h16;
  // value is arbitrary
  localparam logic [7:0] SIGNATURE      = 8'h5a;
  // startup divider defaults
  localparam logic [9:0] DEF_FB         = 10'h1f4;
  localparam logic [2:0] DEF_POST_A     = 3'h2;
  localparam logic       DEF_POST_B     = 1'h0;
  localparam logic       DEF_PRE        = 1'h1;
  // high config byte field positions
  localparam int         HI_FB_POS      = 0;
  localparam int         HI_PA_POS      = 2;
  localparam int         HI_PB_POS      = 5;
  localparam int         HI_PRE_POS     = 6;
  localparam logic [7:0] HI_USED_MASK   = 8'h7f;
  localparam int         PIN_COUNT      = 15;
  // read stream order
  localparam logic [1:0] RD_IDX_LOW     = 2'h0;
  localparam logic [1:0] RD_IDX_HIGH    = 2'h1;
  localparam logic [1:0] RD_IDX_SIG     = 2'h2;
  // startup load waits for the pin synchroniser to fill
  localparam logic [1:0] BOOT_LOAD      = 2'h2;
  localparam logic [1:0] BOOT_DONE      = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_TX_BIT    = 4'h7;

  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_rack} i2c_state_t;

  function automatic logic [7:0] pack_high(input logic [9:0] fb, input logic [2:0] pa,
                                           input logic pb, input logic pre);
    pack_high = {1'b0, pre, pb, pa, fb[9:8]};
  endfunction

  function automatic logic [1:0] next_idx(input logic [1:0] idx);
    next_idx = (idx == RD_IDX_SIG) ? idx : idx + 2'h1;
  endfunction
endpackage

// ===== verilog/synth_divider_config_port.sv
// Purpose: divider settings front end, parallel pins or serial registers
// Assumes: reset_n is the master reset pin; unconnected pins pulled to defaults
// Notes: all pins but reset_n pass two flops before use, so pin changes land after two cycles
`timescale 1ns/1ns
`default_nettype none
module synth_divider_config_port (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       parallel_select_n,
  input  wire logic [1:0] addr_sel,
  input  wire logic [9:0] fb_pins,
  input  wire logic [2:0] post_a_pins,
  input  wire logic       post_b_pin,
  input  wire logic       pre_pin,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic      [9:0] fb_div,
  output logic      [2:0] post_divider_a,
  output logic            post_divider_b,
  output logic            pre_div
);
  cfg_bus_if bus ();

  logic [synth_cfg_pkg::PIN_COUNT+2:0] pins_s;
  logic [9:0] fb_q, fb_d;
  logic [2:0] pa_q, pa_d;
  logic       pb_q, pb_d, pre_q, pre_d;
  logic [7:0] cfg_low_q, cfg_low_d, cfg_high_q, cfg_high_d;
  logic [1:0] boot_q, boot_d;

  pin_sync #(.WIDTH(synth_cfg_pkg::PIN_COUNT + 3)) u_pin_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   ({addr_sel, parallel_select_n, pre_pin, post_b_pin, post_a_pins, fb_pins}),
    .pin_out  (pins_s)
  );

  i2c_slave_port u_port (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .scl      (scl),
    .sda_in   (sda_in),
    .addr_sel (pins_s[17:16]),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .bus      (bus.port_side)
  );

  wire [9:0] pin_fb   = pins_s[9:0];
  wire [2:0] pin_pa   = pins_s[12:10];
  wire       pin_pb   = pins_s[13];
  wire       pin_pre  = pins_s[14];
  wire       serial   = pins_s[15];
  wire       boot_load = (boot_q == synth_cfg_pkg::BOOT_LOAD);
  // hold reset defaults until the synchronised pins are valid
  wire       boot_done = (boot_q == synth_cfg_pkg::BOOT_DONE);
  wire       follow   = boot_load | (~serial & boot_done);
  wire       wr_ok    = bus.wr_stb & serial & boot_done;
  wire       wr_low   = wr_ok & (bus.wr_addr == synth_cfg_pkg::ADDR_CFG_LOW);
  wire       wr_high  = wr_ok & (bus.wr_addr == synth_cfg_pkg::ADDR_CFG_HIGH);
  wire       wr_cmd   = wr_ok & (bus.wr_addr == synth_cfg_pkg::ADDR_COMMAND);
  wire       commit   = wr_cmd & (bus.wr_data == synth_cfg_pkg::CMD_COMMIT);
  wire       capture  = wr_cmd & (bus.wr_data == synth_cfg_pkg::CMD_CAPTURE);
  wire       step_up  = wr_cmd & (bus.wr_data == synth_cfg_pkg::CMD_STEP_UP);
  wire       step_dn  = wr_cmd & (bus.wr_data == synth_cfg_pkg::CMD_STEP_DOWN);
  wire [9:0] cfg_fb   = {cfg_high_q[synth_cfg_pkg::HI_FB_POS +: 2], cfg_low_q};
  wire [2:0] cfg_pa   = cfg_high_q[synth_cfg_pkg::HI_PA_POS +: 3];
  wire       cfg_pb   = cfg_high_q[synth_cfg_pkg::HI_PB_POS];
  wire       cfg_pre  = cfg_high_q[synth_cfg_pkg::HI_PRE_POS];
  wire [7:0] pin_high = synth_cfg_pkg::pack_high(pin_fb, pin_pa, pin_pb, pin_pre);
  wire [7:0] lat_high = synth_cfg_pkg::pack_high(fb_q, pa_q, pb_q, pre_q);

  // read stream never reaches the command register
  assign bus.rd_data = (bus.rd_idx == synth_cfg_pkg::RD_IDX_LOW)  ? cfg_low_q :
                       (bus.rd_idx == synth_cfg_pkg::RD_IDX_HIGH) ? cfg_high_q :
                       synth_cfg_pkg::SIGNATURE;

  assign boot_d = (boot_q == synth_cfg_pkg::BOOT_DONE) ? boot_q : boot_q + 2'h1;

  // steps wrap freely, validity is left to the host
  assign fb_d  = follow  ? pin_fb :
                 commit  ? cfg_fb :
                 step_up ? fb_q + 10'h1 :
                 step_dn ? fb_q - 10'h1 : fb_q;
  assign pa_d  = follow ? pin_pa  : commit ? cfg_pa  : pa_q;
  assign pb_d  = follow ? pin_pb  : commit ? cfg_pb  : pb_q;
  assign pre_d = follow ? pin_pre : commit ? cfg_pre : pre_q;

  assign cfg_low_d  = follow  ? pin_fb[7:0] :
                      capture ? fb_q[7:0] :
                      wr_low  ? bus.wr_data : cfg_low_q;
  assign cfg_high_d = follow  ? pin_high :
                      capture ? lat_high :
                      wr_high ? (bus.wr_data & synth_cfg_pkg::HI_USED_MASK) : cfg_high_q;

  assign fb_div         = fb_q;
  assign post_divider_a = pa_q;
  assign post_divider_b = pb_q;
  assign pre_div        = pre_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_q     <= 2'h0;
      fb_q       <= synth_cfg_pkg::DEF_FB;
      pa_q       <= synth_cfg_pkg::DEF_POST_A;
      pb_q       <= synth_cfg_pkg::DEF_POST_B;
      pre_q      <= synth_cfg_pkg::DEF_PRE;
      cfg_low_q  <= synth_cfg_pkg::DEF_FB[7:0];
      cfg_high_q <= synth_cfg_pkg::pack_high(synth_cfg_pkg::DEF_FB, synth_cfg_pkg::DEF_POST_A,
                                             synth_cfg_pkg::DEF_POST_B, synth_cfg_pkg::DEF_PRE);
    end else begin
      boot_q     <= boot_d;
      fb_q       <= fb_d;
      pa_q       <= pa_d;
      pb_q       <= pb_d;
      pre_q      <= pre_d;
      cfg_low_q  <= cfg_low_d;
      cfg_high_q <= cfg_high_d;
    end
  end

  property p_par_follow;
    @(posedge core_clk) disable iff (!reset_n)
    (!serial && boot_done) |=> (fb_q == $past(pin_fb)) && (pa_q == $past(pin_pa)) && (pre_q == $past(pin_pre));
  endproperty
  a_par_follow: assert property (p_par_follow)
    else $error("dividers not following pins in parallel mode");

  property p_boot_load;
    @(posedge core_clk) disable iff (!reset_n)
    boot_load |=> (fb_q == $past(pin_fb)) && (pb_q == $past(pin_pb));
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("startup load missed pins");

  property p_par_ignore_wr;
    @(posedge core_clk) disable iff (!reset_n)
    (bus.wr_stb && !serial) |=> (cfg_low_q == $past(pin_fb[7:0])) && (fb_q == $past(pin_fb));
  endproperty
  a_par_ignore_wr: assert property (p_par_ignore_wr)
    else $error("write took effect in parallel mode");

  property p_mirror;
    @(posedge core_clk) disable iff (!reset_n)
    (!serial && $past(!serial)) |-> (cfg_low_q == fb_q[7:0]) && (cfg_high_q == lat_high);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("config registers not mirroring dividers");

  property p_serial_hold;
    @(posedge core_clk) disable iff (!reset_n)
    (serial && !bus.wr_stb && !boot_load) |=> $stable(fb_q) && $stable(cfg_low_q) && $stable(cfg_high_q);
  endproperty
  a_serial_hold: assert property (p_serial_hold)
    else $error("state changed in serial mode without a write");

  property p_leave_serial;
    @(posedge core_clk) disable iff (!reset_n)
    $fell(serial) |=> (cfg_low_q == $past(pin_fb[7:0])) && (fb_q == $past(pin_fb));
  endproperty
  a_leave_serial: assert property (p_leave_serial)
    else $error("falling mode select did not reload pins");

  property p_commit;
    @(posedge core_clk) disable iff (!reset_n)
    commit |=> (fb_q == $past(cfg_fb)) && (pa_q == $past(cfg_pa)) && (pre_q == $past(cfg_pre));
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit did not load dividers");

  property p_capture;
    @(posedge core_clk) disable iff (!reset_n)
    capture |=> (cfg_low_q == $past(fb_q[7:0])) && (cfg_high_q == $past(lat_high)) && $stable(fb_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy dividers");

  property p_step;
    @(posedge core_clk) disable iff (!reset_n)
    (step_up || step_dn) |=> (fb_q == ($past(step_up) ? 10'($past(fb_q) + 10'h1) : 10'($past(fb_q) - 10'h1)))
                              && $stable(cfg_low_q) && $stable(cfg_high_q);
  endproperty
  a_step: assert property (p_step)
    else $error("step command wrong");

endmodule // synth_divider_config_port
`default_nettype wire
